// ===== include/fsb_pkg.sv
package fsb_pkg;
  localparam int AW = 24;
  localparam int DW = 16;
  // command words
  localparam logic [15:0] CMD_UNLOCK1 = 16'h00aa;
  localparam logic [15:0] CMD_UNLOCK2 = 16'h0055;
  localparam logic [15:0] CMD_BYP_ENTRY = 16'h0020;
  localparam logic [15:0] CMD_SUSPEND = 16'h00b0;
  localparam logic [15:0] CMD_RESUME = 16'h0030;
  localparam logic [15:0] CMD_PROG_SETUP = 16'h00a0;
  localparam logic [15:0] CMD_BYP_EXIT1 = 16'h0090;
  localparam logic [15:0] CMD_BYP_EXIT2 = 16'h0000;
  localparam logic [15:0] CMD_RESET = 16'h00f0;
  localparam logic [23:0] ADDR_UNLOCK1 = 24'h000555;
  localparam logic [23:0] ADDR_UNLOCK2 = 24'h0002aa;
  localparam logic [23:0] ADDR_ANY = 24'h000000;
  // bus timing at 100 MHz: strobe low and high phases
  localparam int CLK_NS = 10;
  localparam int WE_LOW_NS = 40;
  localparam int WE_HIGH_NS = 30;
  localparam int RD_NS = 80;
  localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_HIGH_CYC = (WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC = (RD_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  // suspend latencies the host waits out before using the array
  localparam int ERS_SUSP_US = 20;
  localparam int PRG_SUSP_US = 15;
  localparam int ERS_SUSP_CYC = ERS_SUSP_US * 1000 / CLK_NS;
  localparam int PRG_SUSP_CYC = PRG_SUSP_US * 1000 / CLK_NS;
  localparam int WAIT_W = 12;
  localparam int MAX_SECTOR_PROGS = 10;
  localparam int POLL_BIT = 7;
  // host-side operations
  typedef enum logic [3:0] {
    OP_READ = 4'h0, OP_ERS_SUSPEND = 4'h1, OP_ERS_RESUME = 4'h2,
    OP_PRG_SUSPEND = 4'h3, OP_PRG_RESUME = 4'h4, OP_BYP_ENTER = 4'h5,
    OP_BYP_PROGRAM = 4'h6, OP_BYP_EXIT = 4'h7, OP_ABORT_RESET = 4'h8
  } fsb_op_t;
  typedef struct packed {
    fsb_op_t op;
    logic [23:0] addr;
    logic [15:0] data;
  } fsb_req_t;
  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] dOut;
    logic weN;
    logic oeN;
    logic ceN;
    logic dqOeN;
  } fsb_pins_t;
endpackage

// ===== logic/fsb_bus_cycle.sv
`timescale 1ns/1ns
`default_nettype none
// one asynchronous bus write or read, timed from clk_sys
module fsb_bus_cycle (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic start,
  input wire logic isRead,
  input wire logic [23:0] addr,
  input wire logic [15:0] data,
  input wire logic [15:0] dqIn,
  output fsb_pkg::fsb_pins_t pins,
  output logic done,
  output logic [15:0] rdData
);
  typedef enum logic [1:0] {
    BC_IDLE = 2'b00, BC_LOW = 2'b01, BC_HIGH = 2'b10
  } fsb_bc_t;
  fsb_bc_t st_q, st_d;
  logic [fsb_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic rd_q, rd_d;
  fsb_pkg::fsb_pins_t pins_q, pins_d;
  logic done_q, done_d;
  logic [15:0] rdData_q, rdData_d;

  // strobe sequencer; read data taken just before oe rises
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    rd_d = rd_q;
    pins_d = pins_q;
    done_d = 1'b0;
    rdData_d = rdData_q;
    case (st_q)
      BC_IDLE: begin
        if (start) begin
          st_d = BC_LOW;
          rd_d = isRead;
          pins_d.addr = addr;
          pins_d.dOut = data;
          pins_d.ceN = 1'b0;
          pins_d.weN = isRead;
          pins_d.oeN = !isRead;
          pins_d.dqOeN = isRead; // low while we drive dq
          cnt_d = rd_d ? fsb_pkg::CNT_W'(fsb_pkg::RD_CYC)
                       : fsb_pkg::CNT_W'(fsb_pkg::WE_LOW_CYC);
        end
      end
      BC_LOW: begin
        if (cnt_q == fsb_pkg::CNT_ONE) begin
          st_d = BC_HIGH;
          if (rd_q) rdData_d = dqIn;
          pins_d.weN = 1'b1;
          pins_d.oeN = 1'b1;
          pins_d.ceN = 1'b1;
          cnt_d = fsb_pkg::CNT_W'(fsb_pkg::WE_HIGH_CYC);
        end else begin
          cnt_d = cnt_q - fsb_pkg::CNT_ONE;
        end
      end
      BC_HIGH: begin
        // hold data past we rise, then release the bus
        if (cnt_q == fsb_pkg::CNT_ONE) begin
          st_d = BC_IDLE;
          pins_d.dqOeN = 1'b1;
          done_d = 1'b1;
        end else begin
          cnt_d = cnt_q - fsb_pkg::CNT_ONE;
        end
      end
      default: st_d = BC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_q <= BC_IDLE;
      cnt_q <= '0;
      rd_q <= 1'b0;
      pins_q <= '{addr: '0, dOut: '0, weN: 1'b1, oeN: 1'b1, ceN: 1'b1, dqOeN: 1'b1};
      done_q <= 1'b0;
      rdData_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      rd_q <= rd_d;
      pins_q <= pins_d;
      done_q <= done_d;
      rdData_q <= rdData_d;
    end
  end

  assign pins = pins_q;
  assign done = done_q;
  assign rdData = rdData_q;
endmodule
`default_nettype wire

// ===== logic/fsb_host_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - erase resume is one write of 0030h; repeated resumes harmless
// - program resume is one 0030h write; later suspend allowed
// - abort in accelerated mode uses full three-write reset
// - at most ten accelerated programs per sector; unprotect first (the host neither counts programs nor unprotects)
// - leave reduced-cycle mode with 90h then 00h
// - enter reduced-cycle mode: aa@555, 55@2aa, 20@555
// - reduced program: a0h setup then data at target
module fsb_host_ctrl (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic reqValid,
  input wire fsb_pkg::fsb_req_t req,
  input wire logic sectorErasing,
  input wire logic chipErasing,
  input wire logic programming,
  input wire logic accelRequest,
  input wire logic [15:0] dqIn,
  output logic reqReady,
  output logic reqRefused,
  output logic rspValid,
  output logic [15:0] rspData,
  output logic eraseSuspended,
  output logic progSuspended,
  output logic bypassActive,
  output logic accelOn,
  output fsb_pkg::fsb_pins_t pins
);
  typedef enum logic [2:0] {
    HS_IDLE = 3'b000, HS_WRITE = 3'b001, HS_WAIT_BUS = 3'b010,
    HS_SETTLE = 3'b011, HS_DONE = 3'b100
  } fsb_hs_t;
  fsb_hs_t st_q, st_d;
  fsb_pkg::fsb_req_t cur_q, cur_d;
  logic [1:0] idx_q, idx_d;
  logic [1:0] nWr_q, nWr_d;
  logic [fsb_pkg::WAIT_W-1:0] wait_q, wait_d;
  logic ersSusp_q, ersSusp_d, prgSusp_q, prgSusp_d, byp_q, byp_d, acc_q, acc_d;
  logic ready_q, ready_d, refused_q, refused_d, rsp_q, rsp_d;
  logic [15:0] rspData_q, rspData_d;
  logic busStart, busRead, busDone;
  logic [23:0] busAddr;
  logic [15:0] busData, busRd;
  logic ok;

  // write sequence table for the current operation
  always_comb begin
    busAddr = fsb_pkg::ADDR_ANY;
    busData = fsb_pkg::CMD_BYP_EXIT2;
    case (cur_q.op)
      fsb_pkg::OP_ERS_SUSPEND, fsb_pkg::OP_PRG_SUSPEND: busData = fsb_pkg::CMD_SUSPEND;
      fsb_pkg::OP_ERS_RESUME, fsb_pkg::OP_PRG_RESUME: busData = fsb_pkg::CMD_RESUME;
      fsb_pkg::OP_BYP_ENTER, fsb_pkg::OP_ABORT_RESET: begin
        // unlock pair then command at 555
        busAddr = (idx_q == 2'd1) ? fsb_pkg::ADDR_UNLOCK2 : fsb_pkg::ADDR_UNLOCK1;
        busData = (idx_q == 2'd0) ? fsb_pkg::CMD_UNLOCK1
                : (idx_q == 2'd1) ? fsb_pkg::CMD_UNLOCK2
                : (cur_q.op == fsb_pkg::OP_BYP_ENTER) ? fsb_pkg::CMD_BYP_ENTRY
                : fsb_pkg::CMD_RESET;
      end
      fsb_pkg::OP_BYP_PROGRAM: begin
        busAddr = (idx_q == 2'd0) ? fsb_pkg::ADDR_ANY : cur_q.addr;
        busData = (idx_q == 2'd0) ? fsb_pkg::CMD_PROG_SETUP : cur_q.data;
      end
      fsb_pkg::OP_BYP_EXIT: busData = (idx_q == 2'd0) ? fsb_pkg::CMD_BYP_EXIT1
                                                    : fsb_pkg::CMD_BYP_EXIT2;
      default: busAddr = cur_q.addr; // array or status read
    endcase
  end

  // legality of a request against tracked device state
  always_comb begin
    case (req.op)
      fsb_pkg::OP_ERS_SUSPEND: ok = sectorErasing && !chipErasing && !ersSusp_q;
      fsb_pkg::OP_ERS_RESUME: ok = ersSusp_q && !prgSusp_q;
      fsb_pkg::OP_PRG_SUSPEND: ok = programming && !prgSusp_q && !byp_q;
      fsb_pkg::OP_PRG_RESUME: ok = prgSusp_q;
      fsb_pkg::OP_BYP_ENTER: ok = !byp_q && !ersSusp_q && !prgSusp_q;
      fsb_pkg::OP_BYP_PROGRAM: ok = byp_q;
      fsb_pkg::OP_BYP_EXIT: ok = byp_q && !acc_q;
      fsb_pkg::OP_ABORT_RESET: ok = 1'b1;
      fsb_pkg::OP_READ: ok = !chipErasing;
      default: ok = 1'b0;
    endcase
  end

  // request sequencer and mode tracking
  always_comb begin
    st_d = st_q;
    cur_d = cur_q;
    idx_d = idx_q;
    nWr_d = nWr_q;
    wait_d = wait_q;
    ersSusp_d = ersSusp_q; // held through program and query
    prgSusp_d = prgSusp_q;
    byp_d = byp_q;
    acc_d = accelRequest; // pin level mirrors request
    ready_d = 1'b0;
    refused_d = 1'b0;
    rsp_d = 1'b0;
    rspData_d = rspData_q;
    busStart = 1'b0;
    busRead = 1'b0;
    if (accelRequest) byp_d = 1'b1;
    else if (acc_q) byp_d = 1'b0; // dropping the voltage restores normal mode
    case (st_q)
      HS_IDLE: begin
        ready_d = 1'b1;
        if (reqValid && ready_q) begin
          ready_d = 1'b0;
          if (!ok) begin
            refused_d = 1'b1;
          end else begin
            cur_d = req;
            idx_d = 2'd0;
            st_d = HS_WRITE;
            case (req.op)
              fsb_pkg::OP_BYP_ENTER, fsb_pkg::OP_ABORT_RESET: nWr_d = 2'd2;
              fsb_pkg::OP_BYP_PROGRAM, fsb_pkg::OP_BYP_EXIT: nWr_d = 2'd1;
              default: nWr_d = 2'd0;
            endcase
          end
        end
      end
      HS_WRITE: begin
        busStart = 1'b1;
        busRead = (cur_q.op == fsb_pkg::OP_READ);
        st_d = HS_WAIT_BUS;
      end
      HS_WAIT_BUS: begin
        if (busDone) begin
          if (idx_q != nWr_q) begin
            idx_d = idx_q + 2'd1;
            st_d = HS_WRITE;
          end else begin
            st_d = HS_DONE;
            wait_d = '0;
            case (cur_q.op)
              fsb_pkg::OP_ERS_SUSPEND: begin
                ersSusp_d = 1'b1;
                wait_d = fsb_pkg::WAIT_W'(fsb_pkg::ERS_SUSP_CYC);
              end
              fsb_pkg::OP_PRG_SUSPEND: begin
                prgSusp_d = 1'b1; // query leaves this set
                wait_d = fsb_pkg::WAIT_W'(fsb_pkg::PRG_SUSP_CYC);
              end
              fsb_pkg::OP_ERS_RESUME: ersSusp_d = 1'b0;
              fsb_pkg::OP_PRG_RESUME: prgSusp_d = 1'b0;
              fsb_pkg::OP_BYP_ENTER: byp_d = 1'b1;
              fsb_pkg::OP_BYP_EXIT: byp_d = 1'b0;
              default: ;
            endcase
            if (wait_d != '0) st_d = HS_SETTLE;
          end
        end
      end
      HS_SETTLE: begin
        // array not touched until the suspend latency has passed
        if (wait_q == fsb_pkg::WAIT_W'(1)) st_d = HS_DONE;
        wait_d = wait_q - fsb_pkg::WAIT_W'(1);
      end
      HS_DONE: begin
        rsp_d = 1'b1;
        rspData_d = busRd; // status bit seen here in erased sector
        st_d = HS_IDLE;
      end
      default: st_d = HS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_q <= HS_IDLE;
      cur_q <= '0;
      idx_q <= 2'd0;
      nWr_q <= 2'd0;
      wait_q <= '0;
      ersSusp_q <= 1'b0;
      prgSusp_q <= 1'b0;
      byp_q <= 1'b0;
      acc_q <= 1'b0;
      ready_q <= 1'b0;
      refused_q <= 1'b0;
      rsp_q <= 1'b0;
      rspData_q <= '0;
    end else begin
      st_q <= st_d;
      cur_q <= cur_d;
      idx_q <= idx_d;
      nWr_q <= nWr_d;
      wait_q <= wait_d;
      ersSusp_q <= ersSusp_d;
      prgSusp_q <= prgSusp_d;
      byp_q <= byp_d;
      acc_q <= acc_d;
      ready_q <= ready_d;
      refused_q <= refused_d;
      rsp_q <= rsp_d;
      rspData_q <= rspData_d;
    end
  end

  fsb_bus_cycle u_bus (
    .clk_sys(clk_sys),
    .srst(srst),
    .start(busStart),
    .isRead(busRead),
    .addr(busAddr),
    .data(busData),
    .dqIn(dqIn),
    .pins(pins),
    .done(busDone),
    .rdData(busRd)
  );

  assign reqReady = ready_q;
  assign reqRefused = refused_q;
  assign rspValid = rsp_q;
  assign rspData = rspData_q;
  assign eraseSuspended = ersSusp_q;
  assign progSuspended = prgSusp_q;
  assign bypassActive = byp_q;
  assign accelOn = acc_q;
endmodule
`default_nettype wire

// ===== tb/fsb_host_props.sv
`timescale 1ns/1ns
`default_nettype none
module fsb_host_props (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic reqValid,
  input wire fsb_pkg::fsb_req_t req,
  input wire logic sectorErasing,
  input wire logic chipErasing,
  input wire logic programming,
  input wire logic accelRequest,
  input wire logic [15:0] dqIn,
  input wire logic reqReady,
  input wire logic reqRefused,
  input wire logic rspValid,
  input wire logic [15:0] rspData,
  input wire logic eraseSuspended,
  input wire logic progSuspended,
  input wire logic bypassActive,
  input wire logic accelOn,
  input wire fsb_pkg::fsb_pins_t pins
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic take;
  // a request counts only when both sides agree on the edge
  assign take = reqValid && reqReady;
  a_susp_no_erase: assert property (take && req.op == fsb_pkg::OP_ERS_SUSPEND && !sectorErasing
    |=> reqRefused) else $error("erase suspend taken without erase");
  a_susp_chip_erase: assert property (take && req.op == fsb_pkg::OP_ERS_SUSPEND && chipErasing
    |=> reqRefused) else $error("erase suspend taken in chip erase");
  logic ersPend_q;
  logic [fsb_pkg::WAIT_W-1:0] ersWait_q;
  // cycles since a legal erase suspend was taken; saturates so a hang cannot wrap it
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ersPend_q <= 1'b0;
      ersWait_q <= '0;
    end else if (take && req.op == fsb_pkg::OP_ERS_SUSPEND && sectorErasing && !chipErasing
                 && !eraseSuspended) begin
      ersPend_q <= 1'b1;
      ersWait_q <= '0;
    end else if (rspValid) begin
      ersPend_q <= 1'b0;
    end else if (ersPend_q && ersWait_q != '1) begin
      ersWait_q <= ersWait_q + fsb_pkg::WAIT_W'(1);
    end
  end
  a_susp_sets_flag: assert property (take && req.op == fsb_pkg::OP_ERS_SUSPEND && sectorErasing
    && !chipErasing && !eraseSuspended |-> ##[1:16] eraseSuspended)
    else $error("erase suspend flag late");
  a_susp_latency: assert property (ersPend_q && rspValid
    |-> ersWait_q >= fsb_pkg::WAIT_W'(fsb_pkg::ERS_SUSP_CYC))
    else $error("erase suspend answered before latency");
  a_resume_repeat: assert property (take && req.op == fsb_pkg::OP_ERS_RESUME && !eraseSuspended
    |=> reqRefused) else $error("extra erase resume sent");
  a_prog_resume_repeat: assert property (take && req.op == fsb_pkg::OP_PRG_RESUME
    && !progSuspended |=> reqRefused) else $error("extra program resume sent");
  a_byp_no_suspend: assert property (take && req.op == fsb_pkg::OP_PRG_SUSPEND && bypassActive
    |=> reqRefused) else $error("suspend sent in bypass");
  a_exit_accel_kept: assert property (take && req.op == fsb_pkg::OP_BYP_EXIT && accelOn
    |=> reqRefused) else $error("bypass exit sent under accel");
  a_accel_bypass: assert property ($rose(accelOn) |-> ##[0:4] bypassActive)
    else $error("accel without bypass");
  a_refuse_no_write: assert property (reqRefused |-> pins.weN && pins.ceN)
    else $error("bus active on refusal");
  a_write_drives_bus: assert property (!pins.weN |-> !pins.dqOeN && !pins.ceN)
    else $error("write strobe without bus drive");
  c_bypass_entry: cover property (take && req.op == fsb_pkg::OP_BYP_ENTER);
  c_nested_susp: cover property (eraseSuspended && progSuspended);
  c_refused: cover property (reqRefused);
  c_accel: cover property (accelOn && rspValid);
endmodule
bind fsb_host_ctrl fsb_host_props u_props (.clk_sys, .srst, .reqValid, .req, .sectorErasing,
  .chipErasing, .programming, .accelRequest, .dqIn, .reqReady, .reqRefused, .rspValid,
  .rspData, .eraseSuspended, .progSuspended, .bypassActive, .accelOn, .pins);
`default_nettype wire

// ===== tb/fsb_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
module fsb_flash_model #(
  parameter logic [7:0] ERS_SECT = 8'h01
) (
  input wire fsb_pkg::fsb_pins_t pins,
  input wire logic sectorErasing,
  input wire logic chipErasing,
  input wire logic programming,
  input wire logic accelOn,
  output logic [15:0] dqIn
);
  logic [39:0] wq[$];
  logic ersS = 1'b0;
  logic prgS = 1'b0;
  logic byp = 1'b0;
  logic exitArm = 1'b0;
  logic [1:0] us = 2'h0;
  logic [15:0] rd;
  logic [15:0] lastRd = 16'h0000;
  wire bypEff = byp || accelOn;
  // suspended sector answers with status, polling bit high
  assign rd = (ersS && pins.addr[23:16] == ERS_SECT) ? 16'h0080 : (pins.addr[15:0] ^ 16'h3c3c);
  // released bus shows the inverse so a stale value never passes
  assign dqIn = (!pins.ceN && !pins.oeN) ? rd : ~lastRd;
  always @(posedge pins.oeN) lastRd <= rd;
  // latch on falling strobe once address and data have settled
  always @(negedge pins.weN) begin
    #1;
    if (!pins.ceN) begin
      wq.push_back({pins.addr, pins.dOut});
      // unlock pair, then entry or abort code
      if (pins.dOut == 16'h00aa && pins.addr == 24'h000555) us = 2'h1;
      else if (us == 2'h1 && pins.dOut == 16'h0055 && pins.addr == 24'h0002aa) us = 2'h2;
      else begin
        if (us == 2'h2 && pins.dOut == 16'h0020 && pins.addr == 24'h000555) byp = 1'b1;
        // two-write exit, address ignored
        if (byp && exitArm && pins.dOut == 16'h0000) byp = 1'b0;
        exitArm = byp && pins.dOut == 16'h0090;
        // suspend acts at once, well inside its bound
        if (pins.dOut == 16'h00b0 && !bypEff) begin
          if (programming) prgS = 1'b1;
          else if (sectorErasing && !chipErasing) ersS = 1'b1;
        end
        // program resumes first; a repeat then resumes the erase
        if (pins.dOut == 16'h0030 && !bypEff) begin
          if (prgS) prgS = 1'b0;
          else ersS = 1'b0;
        end
        us = 2'h0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk_sys = 1'b0;
  logic srst, reqValid, sectorErasing, chipErasing, programming, accelRequest;
  fsb_pkg::fsb_req_t req;
  logic reqReady, reqRefused, rspValid, eraseSuspended, progSuspended, bypassActive, accelOn;
  logic [15:0] rspData, dqIn, d;
  logic [23:0] a;
  fsb_pkg::fsb_pins_t pins;
  int checks = 0;
  int mismatches = 0;
  int q0, i;
  fsb_host_ctrl u_dut (.clk_sys(clk_sys), .srst(srst), .reqValid(reqValid), .req(req),
    .sectorErasing(sectorErasing), .chipErasing(chipErasing), .programming(programming),
    .accelRequest(accelRequest), .dqIn(dqIn), .reqReady(reqReady), .reqRefused(reqRefused),
    .rspValid(rspValid), .rspData(rspData), .eraseSuspended(eraseSuspended),
    .progSuspended(progSuspended), .bypassActive(bypassActive), .accelOn(accelOn), .pins(pins));
  fsb_flash_model u_flash (.pins(pins), .sectorErasing(sectorErasing),
    .chipErasing(chipErasing), .programming(programming), .accelOn(accelOn), .dqIn(dqIn));
  initial forever #5 clk_sys = ~clk_sys;
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // array contents the model holds outside suspended sectors
  function automatic logic [15:0] arr(input logic [23:0] ad);
    return ad[15:0] ^ 16'h3c3c;
  endfunction
  // one request, raised for one cycle once ready is seen; counts bus writes the device saw
  task automatic doReq(input fsb_pkg::fsb_op_t op, input logic [23:0] ad, input logic [15:0] dt,
                       input logic refd, input int nw);
    int n;
    n = 0;
    while (reqReady !== 1'b1 && n < 50) begin @(posedge clk_sys); #1; n++; end
    q0 = u_flash.wq.size();
    req = '{op, ad, dt};
    reqValid = 1'b1;
    @(posedge clk_sys); #1;
    reqValid = 1'b0;
    n = 0;
    while (reqRefused !== 1'b1 && rspValid !== 1'b1 && n < 3000) begin
      @(posedge clk_sys); #1; n++;
    end
    chk("refused", 32'(refd), 32'(reqRefused));
    chk("write count", 32'(nw), 32'(u_flash.wq.size() - q0));
  endtask
  task automatic chkW(input int k, input logic [23:0] ad, input logic [15:0] dt);
    chk("write addr", 32'(ad), 32'(u_flash.wq[q0 + k][39:16]));
    chk("write data", 32'(dt), 32'(u_flash.wq[q0 + k][15:0]));
  endtask
  initial begin
    // whole run is a few thousand cycles, mostly suspend latency
    #300000;
    mismatches++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(32'h30e4));
    srst = 1'b1; reqValid = 1'b0; req = '0; sectorErasing = 1'b0; chipErasing = 1'b0;
    programming = 1'b0; accelRequest = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 srst = 1'b0;
    chk("ready after reset", 32'h0, 32'(reqReady));
    doReq(fsb_pkg::OP_ERS_SUSPEND, 24'h0, 16'h0, 1'b1, 0);
    sectorErasing = 1'b1;
    chipErasing = 1'b1;
    doReq(fsb_pkg::OP_ERS_SUSPEND, 24'h0, 16'h0, 1'b1, 0);
    chipErasing = 1'b0;
    doReq(fsb_pkg::OP_ERS_SUSPEND, 24'($urandom), 16'h0, 1'b0, 1);
    chkW(0, fsb_pkg::ADDR_ANY, fsb_pkg::CMD_SUSPEND);
    chk("erase suspended", 32'h1, 32'(eraseSuspended));
    doReq(fsb_pkg::OP_READ, {8'h01, 16'($urandom)}, 16'h0, 1'b0, 0);
    chk("polling bit", 32'h1, 32'(rspData[7]));
    doReq(fsb_pkg::OP_ERS_SUSPEND, 24'h0, 16'h0, 1'b1, 0);
    programming = 1'b1;
    doReq(fsb_pkg::OP_PRG_SUSPEND, 24'h0, 16'h0, 1'b0, 1);
    chk("nested suspend", 32'h3, 32'({eraseSuspended, progSuspended}));
    doReq(fsb_pkg::OP_PRG_RESUME, 24'h0, 16'h0, 1'b0, 1);
    chkW(0, fsb_pkg::ADDR_ANY, fsb_pkg::CMD_RESUME);
    doReq(fsb_pkg::OP_PRG_RESUME, 24'h0, 16'h0, 1'b1, 0);
    programming = 1'b0;
    doReq(fsb_pkg::OP_ERS_RESUME, 24'h0, 16'h0, 1'b0, 1);
    doReq(fsb_pkg::OP_ERS_RESUME, 24'h0, 16'h0, 1'b1, 0);
    doReq(fsb_pkg::OP_ERS_SUSPEND, 24'h0, 16'h0, 1'b0, 1);
    doReq(fsb_pkg::OP_ERS_RESUME, 24'h0, 16'h0, 1'b0, 1);
    chk("erase resumed", 32'h0, 32'(u_flash.ersS));
    sectorErasing = 1'b0;
    $display("test suspend done");
    doReq(fsb_pkg::OP_BYP_ENTER, 24'h0, 16'h0, 1'b0, 3);
    chkW(0, 24'h000555, 16'h00aa);
    chkW(1, 24'h0002aa, 16'h0055);
    chkW(2, 24'h000555, 16'h0020);
    programming = 1'b1;
    doReq(fsb_pkg::OP_PRG_SUSPEND, 24'h0, 16'h0, 1'b1, 0);
    programming = 1'b0;
    a = 24'($urandom);
    d = 16'($urandom);
    doReq(fsb_pkg::OP_BYP_PROGRAM, a, d, 1'b0, 2);
    chkW(0, fsb_pkg::ADDR_ANY, 16'h00a0);
    chkW(1, a, d);
    doReq(fsb_pkg::OP_BYP_EXIT, 24'h0, 16'h0, 1'b0, 2);
    chkW(0, fsb_pkg::ADDR_ANY, 16'h0090);
    chkW(1, fsb_pkg::ADDR_ANY, 16'h0000);
    chk("bypass left", 32'h0, 32'({bypassActive, u_flash.byp}));
    doReq(fsb_pkg::OP_BYP_PROGRAM, 24'h0, 16'h0, 1'b1, 0);
    $display("test bypass done");
    accelRequest = 1'b1; // one short accelerated spell, sectors left unprotected
    i = 0;
    while (accelOn !== 1'b1 && i < 20) begin @(posedge clk_sys); #1; i++; end
    chk("accel on", 32'h1, 32'(accelOn));
    chk("accel bypass", 32'h1, 32'(bypassActive));
    doReq(fsb_pkg::OP_BYP_EXIT, 24'h0, 16'h0, 1'b1, 0);
    doReq(fsb_pkg::OP_ABORT_RESET, 24'h0, 16'h0, 1'b0, 3);
    chkW(2, 24'h000555, fsb_pkg::CMD_RESET);
    accelRequest = 1'b0;
    i = 0;
    while (bypassActive !== 1'b0 && i < 20) begin @(posedge clk_sys); #1; i++; end
    chk("accel dropped", 32'h0, 32'(bypassActive));
    $display("test accel done");
    repeat (8) begin
      a = {8'h02, 16'($urandom)};
      doReq(fsb_pkg::OP_READ, a, 16'h0, 1'b0, 0);
      chk("array read", 32'(arr(a)), 32'(rspData));
    end
    $display("test reads done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
